// File: hdl/twi_pkg.sv
// shared constants for the two-wire serial memory link: device-address
// layout, page geometry and the timing counts of both ends
// assumes a single 125 MHz core clock on each end
package twi_pkg;
    // device-address byte layout
    localparam logic [3:0] DEVICE_CLASS = 4'hA;
    localparam logic FIXED_SELECT_VALUE = 1'b0;
    localparam int CLASS_MSB = 7;
    localparam int CLASS_LSB = 4;
    localparam int FIXED_SELECT_POS = 3;
    localparam int BLOCK_MSB = 2;
    localparam int BLOCK_LSB = 1;
    localparam int DIR_POS = 0;
    localparam logic DIR_WRITE = 1'b0;

    // memory geometry
    localparam int BYTE_BITS = 8;
    localparam int BLOCK_W = 2;
    localparam int MEM_ADDR_W = 10;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_OFFSET_W = 4;
    localparam int PAGE_BASE_W = MEM_ADDR_W - PAGE_OFFSET_W;
    localparam int LEN_W = 5;

    // bit counter value of the acknowledge clock and of the last data bit
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // timing
    localparam int CORE_CLK_HZ = 125_000_000;
    localparam int CORE_PERIOD_NS = 8;
    localparam int PROGRAMMING_CYCLE_TIME_MS = 10;
    localparam int PROG_CYCLES =
        PROGRAMMING_CYCLE_TIME_MS * (CORE_CLK_HZ / 1000);
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYCLES =
        SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
endpackage

// File: hdl/twi_if.sv
// two-wire link between the bus master and the serial memory
// both lines are open drain with a pull-up; the resolved level is
// formed here from the drivers' enables
`timescale 1ns/1ps
interface twi_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // pulled high unless a driver enables a low
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport host (
        output scl_m_o,
        output scl_m_oe,
        output sda_m_o,
        output sda_m_oe,
        input scl,
        input sda
    );

    modport dev (
        output sda_s_o,
        output sda_s_oe,
        input scl,
        input sda
    );
endinterface

// File: hdl/twi_eeprom_dev.sv
// slave end of the two-wire serial memory: bus conditions, addressing,
// acknowledge, byte and page writes, programming busy period
// assumes the master drives scl; both lines are sampled on core_clk
`timescale 1ns/1ps
module twi_eeprom_dev #(
    parameter int unsigned PROG_CYCLES_P = twi_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link
    twi_if.dev bus,
    // programming stream into the array
    output logic prog_valid,
    output logic [twi_pkg::MEM_ADDR_W-1:0] prog_addr,
    output logic [twi_pkg::BYTE_BITS-1:0] prog_data,
    // status
    output logic busy,
    output logic [twi_pkg::MEM_ADDR_W-1:0] addr_ptr
);
    import twi_pkg::*;

    localparam int PW = $clog2(PROG_CYCLES_P + 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADR,
        ST_WORD,
        ST_DATA,
        ST_READ
    } dev_state_e;

    function automatic logic dev_match(input logic [BYTE_BITS-1:0] b);
        return b[CLASS_MSB:CLASS_LSB] == DEVICE_CLASS &&
            b[FIXED_SELECT_POS] == FIXED_SELECT_VALUE;
    endfunction

    logic [2:0] scl_sy_q;
    logic [2:0] sda_sy_q;
    logic scl_f_q;
    logic sda_f_q;
    logic scl_n;
    logic sda_n;
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    dev_state_e state_q;
    logic [3:0] bit_q;
    logic [BYTE_BITS-2:0] shift_q;
    logic ack_want_q;
    logic sda_oe_q;
    logic byte_done;
    logic [BYTE_BITS-1:0] new_byte;
    logic [BLOCK_W-1:0] block_q;
    logic [PAGE_BASE_W-1:0] page_q;
    logic [PAGE_OFFSET_W-1:0] off_q;
    logic [PAGE_OFFSET_W-1:0] start_off_q;
    logic [BYTE_BITS-1:0] page_mem [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] filled_q;
    logic scanning_q;
    logic [PAGE_OFFSET_W-1:0] scan_q;
    logic [PAGE_OFFSET_W-1:0] scan_idx;
    logic launch;
    logic busy_q;
    logic [PW-1:0] prog_cnt_q;
    logic prog_valid_q;
    logic [MEM_ADDR_W-1:0] prog_addr_q;
    logic [BYTE_BITS-1:0] prog_data_q;
    logic [MEM_ADDR_W-1:0] ptr_q;

    // three-stage capture; a level is taken once stages two and three agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sy_q <= 3'h7;
            sda_sy_q <= 3'h7;
        end else begin
            scl_sy_q <= {scl_sy_q[1:0], bus.scl};
            sda_sy_q <= {sda_sy_q[1:0], bus.sda};
        end
    end

    assign scl_n = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_f_q;
    assign sda_n = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_f_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            scl_f_q <= scl_n;
            sda_f_q <= sda_n;
        end
    end

    assign start_c = scl_f_q & scl_n & sda_f_q & ~sda_n;
    assign stop_c = scl_f_q & scl_n & ~sda_f_q & sda_n;
    // data on sda is taken only at the scl rising edge, so it must settle while scl is low
    assign rise_c = ~scl_f_q & scl_n;
    assign fall_c = scl_f_q & ~scl_n;
    assign byte_done = ~busy_q & ~start_c & ~stop_c & rise_c &
        state_q != ST_IDLE && bit_q == LAST_BIT;
    assign new_byte = {shift_q, sda_f_q};

    // bus sequencing: conditions, bit count and acknowledge drive
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= '0;
            ack_want_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (busy_q) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            ack_want_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_DEVADR;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (rise_c && state_q != ST_IDLE) begin
            if (bit_q == ACK_SLOT) begin
                bit_q <= 4'h0;
            end else begin
                shift_q <= new_byte[BYTE_BITS-2:0];
                bit_q <= bit_q + 4'h1;
            end
            if (bit_q == LAST_BIT) begin
                case (state_q)
                    ST_DEVADR: begin
                        ack_want_q <= dev_match(new_byte);
                        if (!dev_match(new_byte)) begin
                            state_q <= ST_IDLE;
                        end else if (new_byte[DIR_POS] == DIR_WRITE) begin
                            state_q <= ST_WORD;
                        end else begin
                            state_q <= ST_READ;
                        end
                    end
                    ST_WORD: begin
                        ack_want_q <= 1'b1;
                        state_q <= ST_DATA;
                    end
                    ST_DATA: ack_want_q <= 1'b1;
                    // read data is served elsewhere; the link is left free
                    default: ack_want_q <= 1'b0;
                endcase
            end
        end else if (fall_c) begin
            if (bit_q == ACK_SLOT && ack_want_q) begin
                sda_oe_q <= 1'b1;
            end else if (bit_q == 4'h0) begin
                sda_oe_q <= 1'b0;
                ack_want_q <= 1'b0;
            end
        end
    end

    // page buffer: every location remembers the latest byte written to it
    assign scan_idx = start_off_q + scan_q;
    assign launch = ~busy_q & stop_c & state_q == ST_DATA & |filled_q;

    always_ff @(posedge core_clk) begin
        if (byte_done && state_q == ST_DATA) begin
            page_mem[off_q] <= new_byte;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            block_q <= '0;
            page_q <= '0;
            off_q <= '0;
            start_off_q <= '0;
            filled_q <= '0;
            scanning_q <= 1'b0;
            scan_q <= '0;
        end else if (scanning_q) begin
            scan_q <= scan_q + PAGE_OFFSET_W'(1);
            if (scan_q == PAGE_OFFSET_W'(PAGE_BYTES - 1)) begin
                scanning_q <= 1'b0;
                filled_q <= '0;
            end
        end else if (launch) begin
            scanning_q <= 1'b1;
            scan_q <= '0;
        end else if (start_c && !busy_q) begin
            // a repeated start abandons any bytes not yet launched
            filled_q <= '0;
        end else if (byte_done) begin
            case (state_q)
                ST_DEVADR: block_q <= new_byte[BLOCK_MSB:BLOCK_LSB];
                ST_WORD: begin
                    page_q <= {block_q,
                        new_byte[BYTE_BITS-1:PAGE_OFFSET_W]};
                    off_q <= new_byte[PAGE_OFFSET_W-1:0];
                    start_off_q <= new_byte[PAGE_OFFSET_W-1:0];
                end
                ST_DATA: begin
                    filled_q[off_q] <= 1'b1;
                    off_q <= off_q + PAGE_OFFSET_W'(1);
                end
                default: ;
            endcase
        end
    end

    // programming stream, walked from the designated word address
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prog_valid_q <= 1'b0;
            prog_addr_q <= '0;
            prog_data_q <= '0;
        end else begin
            prog_valid_q <= scanning_q & filled_q[scan_idx];
            prog_addr_q <= {page_q, scan_idx};
            prog_data_q <= page_mem[scan_idx];
        end
    end

    // address pointer shared with later current-address reads
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= '0;
        end else if (byte_done && state_q == ST_WORD) begin
            ptr_q <= {block_q, new_byte};
        end else if (byte_done && state_q == ST_DATA) begin
            // once every page location is filled, the pointer rests on the start word
            ptr_q <= {page_q, &filled_q ? start_off_q :
                off_q + PAGE_OFFSET_W'(1)};
        end
    end

    // busy period; polling goes unacknowledged until it ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            prog_cnt_q <= '0;
        end else if (launch) begin
            busy_q <= 1'b1;
            prog_cnt_q <= PW'(PROG_CYCLES_P - 1);
        end else if (busy_q) begin
            if (prog_cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                prog_cnt_q <= prog_cnt_q - PW'(1);
            end
        end
    end

    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_q;
    assign prog_valid = prog_valid_q;
    assign prog_addr = prog_addr_q;
    assign prog_data = prog_data_q;
    assign busy = busy_q;
    assign addr_ptr = ptr_q;
endmodule // twi_eeprom_dev

// File: hdl/twi_host.sv
// bus master end of the two-wire serial memory link, with the write-data
// FIFO that feeds it; issues byte/page writes and acknowledge polls
// assumes the memory on the far side of the interface
`timescale 1ns/1ps
module twi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic ready_q;
    logic push;
    logic pop;

    assign push = in_valid & ready_q;
    assign pop = out_ready & out_valid;
    assign out_valid = count_q != '0;
    assign out_data = mem[rptr_q];
    assign in_ready = ready_q;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wptr_q <= push ? wptr_q + AW'(1) : wptr_q;
            rptr_q <= pop ? rptr_q + AW'(1) : rptr_q;
            count_q <= count_d;
            ready_q <= count_d < (AW+1)'(DEPTH);
        end
    end
endmodule // twi_fifo

module twi_host #(
    parameter int QUARTER = twi_pkg::SCL_QUARTER_CYCLES,
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link
    twi_if.host bus,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_poll,
    input wire logic [twi_pkg::BLOCK_W-1:0] cmd_block,
    input wire logic [twi_pkg::BYTE_BITS-1:0] cmd_word,
    input wire logic [twi_pkg::LEN_W-1:0] cmd_len,
    // write data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [twi_pkg::BYTE_BITS-1:0] wr_data,
    // result
    output logic done,
    output logic acked
);
    import twi_pkg::*;

    localparam int QW = $clog2(QUARTER + 1);

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_e;
    typedef enum logic [1:0] {G_ADDR, G_WORD, G_DATA} stage_e;

    host_state_e state_q;
    stage_e stage_q;
    logic [QW-1:0] div_q;
    logic tick;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [BYTE_BITS-1:0] tx_q;
    logic [LEN_W-1:0] left_q;
    logic poll_q;
    logic [BYTE_BITS-1:0] word_q;
    logic ack_q;
    logic [2:0] sda_sy_q;
    logic sda_f_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic ready_q;
    logic done_q;
    logic acked_q;
    logic f_valid;
    logic [BYTE_BITS-1:0] f_data;
    logic byte_end;
    logic finish;
    logic need_data;
    logic pop;

    twi_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    // quarter-period enable; scl is built from four of them per bit
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == QW'(QUARTER - 1)) ? '0 : div_q + QW'(1);
        end
    end
    assign tick = div_q == QW'(QUARTER - 1);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sda_sy_q <= 3'h7;
            sda_f_q <= 1'b1;
        end else begin
            sda_sy_q <= {sda_sy_q[1:0], bus.sda};
            if (sda_sy_q[1] == sda_sy_q[2]) begin
                sda_f_q <= sda_sy_q[2];
            end
        end
    end

    // end of an acknowledge clock: either stop or move to the next byte
    assign byte_end = tick && state_q == H_BIT && ph_q == 2'h3 &&
        bit_q == ACK_SLOT;
    assign finish = !ack_q || (stage_q == G_ADDR && poll_q) ||
        (stage_q == G_WORD && left_q == '0) ||
        (stage_q == G_DATA && left_q == LEN_W'(1));
    assign need_data = stage_q != G_ADDR;
    // scl is held low while the fifo is empty, stalling the link
    assign pop = byte_end & ~finish & need_data & f_valid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= H_IDLE;
            stage_q <= G_ADDR;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            tx_q <= '0;
            left_q <= '0;
            poll_q <= 1'b0;
            word_q <= '0;
            ack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            acked_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                H_IDLE: if (cmd_valid && ready_q) begin
                    ready_q <= 1'b0;
                    poll_q <= cmd_poll;
                    word_q <= cmd_word;
                    left_q <= cmd_len;
                    // writes only; every transfer but a poll sets the word address first
                    tx_q <= {DEVICE_CLASS, FIXED_SELECT_VALUE, cmd_block,
                        DIR_WRITE};
                    stage_q <= G_ADDR;
                    ph_q <= 2'h0;
                    state_q <= H_START;
                end
                H_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h1: sda_oe_q <= 1'b1;
                        2'h2: scl_oe_q <= 1'b1;
                        2'h3: begin
                            bit_q <= 4'h0;
                            state_q <= H_BIT;
                        end
                        default: ;
                    endcase
                end
                H_BIT: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        // sda moves only in the low half of scl
                        2'h0: sda_oe_q <= (bit_q != ACK_SLOT) &
                            ~tx_q[BYTE_BITS-1];
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: if (bit_q == ACK_SLOT) begin
                            ack_q <= ~sda_f_q;
                        end
                        default: begin
                            scl_oe_q <= 1'b1;
                            if (bit_q != ACK_SLOT) begin
                                tx_q <= {tx_q[BYTE_BITS-2:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end else if (finish) begin
                                acked_q <= ack_q;
                                state_q <= H_STOP;
                            end else if (!need_data) begin
                                tx_q <= word_q;
                                stage_q <= G_WORD;
                                bit_q <= 4'h0;
                            end else if (f_valid) begin
                                tx_q <= f_data;
                                if (stage_q == G_DATA) begin
                                    left_q <= left_q - LEN_W'(1);
                                end
                                stage_q <= G_DATA;
                                bit_q <= 4'h0;
                            end else begin
                                ph_q <= 2'h3;
                            end
                        end
                    endcase
                end
                H_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_oe_q <= 1'b1;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= 1'b0;
                        default: begin
                            done_q <= 1'b1;
                            ready_q <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    endcase
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = scl_oe_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_oe_q;
    assign cmd_ready = ready_q;
    assign done = done_q;
    assign acked = acked_q;
endmodule // twi_host

// File: dv/twi_eeprom_asserts.sv
// checker for the link between the host end and the memory end
// assumes it sits beside the interface, fed by its resolved lines
`timescale 1ns/1ps
module twi_eeprom_asserts #(
    parameter int PROG = 2000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link and memory status
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe,
    input wire logic busy,
    input wire logic prog_valid
);
    logic [31:0] busy_cnt_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // busy period is far too long for a repetition
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 32'h1 : '0;
        end
    end
    AST_NOACK_BUSY: assert property (busy |-> !sda_s_oe)
        else $error("ack driven while busy");
    AST_ACK_SCL_LOW: assert property ($rose(sda_s_oe) |-> !scl)
        else $error("ack began with scl high");
    AST_ACK_LOW: assert property (sda_s_oe |-> !sda)
        else $error("ack not low on the line");
    AST_ACK_SPAN: assert property ($rose(sda_s_oe) |-> sda_s_oe[*8])
        else $error("ack too short");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_q == PROG)
        else $error("busy length wrong");
    AST_BUSY_ONCE: assert property ($fell(busy) |=> !busy[*8])
        else $error("busy retriggered");
    AST_PROG_IN_BUSY: assert property (prog_valid |-> busy)
        else $error("programming outside busy");
    AST_PROG_WINDOW: assert property
        ($rose(busy) |-> ##17 !prog_valid[*8])
        else $error("programming past scan window");
    CV_ACK: cover property ($rose(sda_s_oe));
    CV_PROG: cover property (prog_valid);
    CV_DONE: cover property ($fell(busy));
endmodule // twi_eeprom_asserts

// File: dv/tb_serial_eeprom_twowire_write_slave.sv
// self-checking bench: host end and memory end joined by the interface
// assumes package, interface and both design files compiled first
`timescale 1ns/1ps
module tb_serial_eeprom_twowire_write_slave;
    import twi_pkg::*;
    localparam int PROG = 2000;
    logic core_clk, resetn, cmd_valid, cmd_ready, cmd_poll;
    logic wr_valid, wr_ready, done, acked, prog_valid, busy;
    logic [1:0] cmd_block;
    logic [7:0] cmd_word, wr_data, prog_data;
    logic [4:0] cmd_len;
    logic [9:0] prog_addr, addr_ptr;
    logic [7:0] got [1024];
    int failures, n_checks, n_prog, base, i, k;
    twi_if u_twi_if();
    twi_eeprom_dev #(.PROG_CYCLES_P(PROG)) u_twi_eeprom_dev (
        .core_clk(core_clk), .resetn(resetn), .bus(u_twi_if),
        .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_data(prog_data), .busy(busy), .addr_ptr(addr_ptr));
    twi_host #(.QUARTER(8), .FIFO_DEPTH(32)) u_twi_host (
        .core_clk(core_clk), .resetn(resetn), .bus(u_twi_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_poll(cmd_poll),
        .cmd_block(cmd_block), .cmd_word(cmd_word), .cmd_len(cmd_len),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .done(done), .acked(acked));
    twi_eeprom_asserts #(.PROG(PROG)) u_twi_eeprom_asserts (
        .core_clk(core_clk), .resetn(resetn), .scl(u_twi_if.scl),
        .sda(u_twi_if.sda), .sda_s_oe(u_twi_if.sda_s_oe), .busy(busy),
        .prog_valid(prog_valid));
    // sampled mid-cycle, where the programming stream has settled
    always @(negedge core_clk) begin
        if (prog_valid === 1'b1) begin
            got[prog_addr] <= prog_data;
            n_prog++;
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ready is sampled at the falling edge, the rising edge then takes it
    task automatic push(input logic [7:0] d);
        wr_data = d;
        wr_valid = 1'b1;
        for (int j = 0; wr_ready !== 1'b1; j++) begin
            if (j > 50) begin
                failures++;
                end_of_test();
            end
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask
    task automatic send(input logic p, input logic [1:0] b,
            input logic [7:0] w, input logic [4:0] n);
        {cmd_poll, cmd_block, cmd_word, cmd_len} = {p, b, w, n};
        cmd_valid = 1'b1;
        for (int j = 0; cmd_ready !== 1'b1; j++) begin
            if (j > 50) begin
                failures++;
                end_of_test();
            end
            @(negedge core_clk);
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (int j = 0; done !== 1'b1; j++) begin
            if (j > 20000) begin
                failures++;
                end_of_test();
            end
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask
    task automatic poll_ready();
        send(1'b1, 2'h0, 8'h00, 5'h00);
        chk(acked, 16'h0000);
        for (int j = 0; acked !== 1'b1; j++) begin
            if (j > 20) begin
                failures++;
                end_of_test();
            end
            send(1'b1, 2'h0, 8'h00, 5'h00);
        end
        chk(busy, 16'h0000);
    endtask
    task automatic t_byte(input logic [1:0] b, input logic [7:0] w,
            input logic [7:0] d, input logic [9:0] ptr);
        push(d);
        wr_valid = 1'b0;
        base = n_prog;
        send(1'b0, b, w, 5'h01);
        chk(acked, 16'h0001);
        poll_ready();
        chk(got[{b, w}], d);
        chk(16'(n_prog - base), 16'h0001);
        chk(addr_ptr, ptr);
    endtask
    task automatic t_dummy();
        base = n_prog;
        send(1'b0, 2'h0, 8'h55, 5'h00);
        chk(acked, 16'h0001);
        chk(16'(n_prog - base), 16'h0000);
        chk(addr_ptr, 10'h055);
    endtask
    task automatic t_page();
        for (i = 0; i < 32; i++) push(8'(i));
        chk(wr_ready, 16'h0000); // fifo holds 32 and refuses
        wr_valid = 1'b0;
        base = n_prog;
        send(1'b0, 2'h1, 8'h7C, 5'h14);
        chk(acked, 16'h0001);
        poll_ready();
        chk(16'(n_prog - base), 16'h0010);
        chk(addr_ptr, 10'h17C);
        for (i = 0; i < 16; i++) begin
            k = (i + 4) % 16;
            k = (k < 4) ? k + 16 : k;
            chk(got[10'h170 + 10'(i)], 16'(k));
        end
        send(1'b0, 2'h3, 8'h00, 5'h0C);
        poll_ready();
        for (i = 0; i < 12; i++) begin
            chk(got[10'h300 + 10'(i)], 16'(20 + i));
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {resetn, cmd_valid, cmd_poll, cmd_block, cmd_word, cmd_len} = '0;
        {wr_valid, wr_data} = '0;
        repeat (8) @(negedge core_clk);
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
        t_byte(2'h2, 8'h35, 8'hA5, 10'h236);
        t_byte(2'h0, 8'h3F, 8'h5A, 10'h030);
        t_dummy();
        t_page();
        end_of_test();
    end
endmodule // tb_serial_eeprom_twowire_write_slave
